/* common/mcw_cond_if.sv */
// carrier of the decoded trigger truth vector
`timescale 1ns/1ps
`default_nettype none
interface mcw_cond_if;
    logic [63:0] truth;  // one bit per trigger code
    modport drive (output truth);
    modport sink  (input truth);
endinterface
`default_nettype wire

/* common/mcw_consts.svh */
// constants for the microcore wait table and routing decoder
// Function
// - five-row wait table, relative write fills one row
// - all five rows evaluated in parallel
// - enabled row hit resumes at stored destination
// - destination is instruction address plus offset
// - offset is 5-bit signed, sign-extended first
// - trigger codes: flags low, high, counts, start
// - trigger codes: routed feedback low, drain-source high
// - trigger codes: ALU done, boost high, boost low
// - trigger codes: current feedbacks high then low
// - trigger codes: own routed current high, low
// - 3-bit row select, codes 0 to 4
// - relative write: bits 15,14 set, fields follow
// - current routing picks one of four blocks
// - current routing reset default per core slot
// - current routing opcode pattern in bits 15:2
// - output routing sets three output routings
// - 4-bit routing codes: high, low, undefined
// - output routing reset defaults per core slot
// - output routing word layout and marker bits
`ifndef MCW_CONSTS_SVH
`define MCW_CONSTS_SVH

// table geometry
`define MCW_ROWS          5
// instruction fields
`define MCW_REL_TAG       2'h3
`define MCW_OUT_TAG       2'h2
`define MCW_OUT_LOW       2'h3
`define MCW_CUR_PATTERN   14'h0d5e
`define MCW_OFF_MSB       13
`define MCW_OFF_LSB       9
`define MCW_ROW_MSB       8
`define MCW_ROW_LSB       6
// trigger code bases
`define MCW_T_FLAG_LO     6'h00
`define MCW_T_FLAG_HI     6'h10
`define MCW_T_COUNT       6'h20
`define MCW_T_START_LO    6'h24
`define MCW_T_VDS_LO      6'h26
`define MCW_T_SRC_LO      6'h29
`define MCW_T_VDS_HI      6'h2c
`define MCW_T_ALU_DONE    6'h2f
`define MCW_T_BOOST_HI    6'h30
`define MCW_T_BOOST_LO    6'h31
`define MCW_T_CUR_HI      6'h32
`define MCW_T_CUR_LO      6'h38
`define MCW_T_OWN_HI      6'h3e
`define MCW_T_OWN_LO      6'h3f
// output routing codes
`define MCW_RT_LS_BASE    4'h5
`define MCW_RT_UNDEF      4'hc
// register byte offsets
`define MCW_OFS_CTRL      6'h00
`define MCW_OFS_ROUTE     6'h04
`define MCW_OFS_ENABLE    6'h08
`define MCW_OFS_ROW0      6'h0c
// register fields
`define MCW_CTRL_EVAL     0
`define MCW_CTRL_CLEAR    1
`define MCW_ROW_DEST_LSB  16
// reset values
`define MCW_CTRL_RESET    1'h1
`define MCW_CUR_RST       8'he4
`define MCW_RTA_RST       16'h3210
`define MCW_RTB_RST       16'h8765
`define MCW_RTC_RST       16'h4ba9

`endif

/* common/mcw_pkg.sv */
// types shared by the wait table and routing decoder
package mcw_pkg;
    typedef logic [5:0] mcw_cond_t;   // wait trigger select
    typedef logic [3:0] mcw_route_t;  // output routing select
    typedef logic [1:0] mcw_cur_t;    // current routing select
    typedef logic [2:0] mcw_row_t;    // table row select
endpackage

/* design/mcw_decoder.sv */
// wait table writer, evaluator and routing registers
`timescale 1ns/1ps
`default_nettype none
`include "mcw_consts.svh"
module mcw_decoder #(
    parameter int ADDR_W    = 10,  // code memory address width
    parameter int CORE_SLOT = 0    // 0 uc0ch1,1 uc1ch1,2 uc0ch2,3 uc1ch2
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // register bus
    input  wire logic [5:0]        avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    // instruction issue from the sequencer
    input  wire logic              instr_valid_i,
    input  wire logic [15:0]       instr_word_i,
    input  wire logic [ADDR_W-1:0] instr_addr_i,
    // wait condition sources
    input  wire logic              wait_active_i,
    input  wire logic [15:0]       flag_i,
    input  wire logic [3:0]        term_count_i,
    input  wire logic              start_pin_i,
    input  wire logic [2:0]        route_vds_fb_i,
    input  wire logic [2:0]        route_src_fb_i,
    input  wire logic              alu_done_i,
    input  wire logic              boost_high_i,
    input  wire logic [5:0]        current_fb_i,
    // routing outputs
    output logic [1:0]             current_route_select_o,
    output logic [3:0]             output_route_a_o,
    output logic [3:0]             output_route_b_o,
    output logic [3:0]             output_route_c_o,
    output logic [4:0]             high_side_gate_pin_o,
    output logic [6:0]             low_side_gate_pin_o,
    // jump request to the sequencer
    output logic                   jump_valid_o,
    output logic [ADDR_W-1:0]      jump_addr_o,
    output logic [2:0]             jump_row_o
);
    localparam int ROWS = `MCW_ROWS;

    // refuse sizes the logic cannot serve
    if (ADDR_W < 6 || ADDR_W > 16) begin : g_bad_width
        $error("ADDR_W must lie in 6..16");
    end
    if (CORE_SLOT < 0 || CORE_SLOT > 3) begin : g_bad_slot
        $error("CORE_SLOT must lie in 0..3");
    end

    // per-slot reset values
    localparam logic [1:0] CUR_RST =
        2'((`MCW_CUR_RST >> (2 * CORE_SLOT)) & 8'h03);
    localparam logic [3:0] RTA_RST =
        4'((`MCW_RTA_RST >> (4 * CORE_SLOT)) & 16'h000f);
    localparam logic [3:0] RTB_RST =
        4'((`MCW_RTB_RST >> (4 * CORE_SLOT)) & 16'h000f);
    localparam logic [3:0] RTC_RST =
        4'((`MCW_RTC_RST >> (4 * CORE_SLOT)) & 16'h000f);

    // ---------------- instruction decode ----------------
    wire         is_rel;   // relative wait-row write
    wire         is_cur;   // current routing
    wire         is_out;   // output routing
    wire [2:0]   row_sel;  // addressed row
    wire         row_ok;   // row select in range
    wire [4:0]   off_raw;  // signed offset field
    wire [ADDR_W-1:0] off_ext;  // sign-extended offset
    wire [ADDR_W-1:0] rel_dest; // computed destination

    assign is_rel  = instr_valid_i &&
                     instr_word_i[15:14] == `MCW_REL_TAG;
    assign is_cur  = instr_valid_i &&
                     instr_word_i[15:2] == `MCW_CUR_PATTERN;
    assign is_out  = instr_valid_i &&
                     instr_word_i[15:14] == `MCW_OUT_TAG &&
                     instr_word_i[1:0] == `MCW_OUT_LOW;
    assign row_sel = instr_word_i[`MCW_ROW_MSB:`MCW_ROW_LSB];
    assign row_ok  = row_sel < 3'(ROWS);
    assign off_raw = instr_word_i[`MCW_OFF_MSB:`MCW_OFF_LSB];
    // sign bit copied up before the add
    assign off_ext = ADDR_W'({{(ADDR_W-5){off_raw[4]}}, off_raw});
    assign rel_dest = ADDR_W'(instr_addr_i + off_ext);

    // ---------------- register bus ----------------
    logic        eval_en;      // wait evaluation enable
    wire         acc_done;     // access completes this edge
    wire         wr_ctrl;      // control register write
    wire         tbl_clear;    // clear all row enables
    wire [5:0]   row_ofs;      // offset past first row
    wire [2:0]   rd_idx;       // row index of a read
    wire         rd_row;       // read hits a row register
    wire [2:0]   rd_safe;      // clamped row index
    logic [31:0] rd_word;      // read mux result

    assign acc_done  = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
    assign wr_ctrl   = acc_done & avs_write_i & avs_byteenable_i[0] &
                       avs_address_i == `MCW_OFS_CTRL;
    assign tbl_clear = wr_ctrl & avs_writedata_i[`MCW_CTRL_CLEAR];
    assign row_ofs   = 6'(avs_address_i - `MCW_OFS_ROW0);
    assign rd_idx    = row_ofs[4:2];
    assign rd_row    = avs_address_i >= `MCW_OFS_ROW0 &&
                       row_ofs[1:0] == 2'h0 && row_ofs[5] == 1'b0 &&
                       rd_idx < 3'(ROWS);
    assign rd_safe   = rd_row ? rd_idx : 3'h0;

    // ---------------- wait table storage ----------------
    logic [ADDR_W-1:0]   row_dest [ROWS]; // destination column
    mcw_pkg::mcw_cond_t  row_cond [ROWS]; // trigger column
    logic [ROWS-1:0]     row_en;          // row enabled
    wire  [ROWS-1:0]     row_hit;         // rows whose trigger holds

    // read data selection, reserved bits zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (avs_address_i == `MCW_OFS_CTRL) begin
            rd_word[`MCW_CTRL_EVAL] = eval_en;
        end else if (avs_address_i == `MCW_OFS_ROUTE) begin
            rd_word[15:0] = {output_route_c_o, output_route_b_o,
                             output_route_a_o, 2'h0,
                             current_route_select_o};
        end else if (avs_address_i == `MCW_OFS_ENABLE) begin
            rd_word[ROWS-1:0] = row_en;
        end else if (rd_row) begin
            rd_word[5:0] = row_cond[rd_safe];
            rd_word[`MCW_ROW_DEST_LSB +: ADDR_W] = row_dest[rd_safe];
        end
    end

    // one wait state on every access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= avs_read_i ? rd_word : 32'h0000_0000;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    // control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eval_en <= `MCW_CTRL_RESET;
        end else if (wr_ctrl) begin
            eval_en <= avs_writedata_i[`MCW_CTRL_EVAL];
        end
    end

    // ---------------- trigger truth vector ----------------
    logic start_meta;  // start pin first stage
    logic start_sync;  // start pin, synchronised
    wire  own_cur;     // routed current feedback
    wire  [3:0] cur_blocks; // blocks 1,2,3,4l
    mcw_cond_if cond_bus ();

    // start arrives from a pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_meta <= 1'b0;
            start_sync <= 1'b0;
        end else begin
            start_meta <= start_pin_i;
            start_sync <= start_meta;
        end
    end

    assign cur_blocks = current_fb_i[3:0];
    assign own_cur    = cur_blocks[current_route_select_o];
    // one bit per code, indexed by the trigger select
    assign cond_bus.truth = {
        ~own_cur, own_cur,
        ~current_fb_i, current_fb_i,
        ~boost_high_i, boost_high_i, alu_done_i,
        route_vds_fb_i, ~route_src_fb_i,
        ~route_vds_fb_i,
        start_sync, ~start_sync, term_count_i,
        flag_i, ~flag_i};

    // ---------------- per-row write and evaluation ----------------
    for (genvar r = 0; r < ROWS; r++) begin : g_row
        wire wr_here; // this row written now
        assign wr_here = is_rel && row_ok && row_sel == 3'(r);
        // row kept until rewritten; write wins over clear
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                row_en[r]   <= 1'b0;
                row_dest[r] <= '0;
                row_cond[r] <= `MCW_T_FLAG_LO;
            end else if (wr_here) begin
                row_en[r]   <= 1'b1;
                row_dest[r] <= rel_dest;
                row_cond[r] <= instr_word_i[5:0];
            end else if (tbl_clear) begin
                row_en[r]   <= 1'b0;
            end
        end
        // every row watched at once
        mcw_row_eval i_mcw_row_eval (
            .cond     (cond_bus),
            .enable_i (row_en[r]),
            .code_i   (row_cond[r]),
            .hit_o    (row_hit[r])
        );
    end

    // lowest numbered hit row wins
    logic [ADDR_W-1:0] sel_dest; // winning destination
    logic [2:0]        sel_row;  // winning row
    always_comb begin
        sel_dest = '0;
        sel_row  = 3'h0;
        for (int i = ROWS - 1; i >= 0; i--) begin
            if (row_hit[i]) begin
                sel_dest = row_dest[i];
                sel_row  = 3'(i);
            end
        end
    end

    wire take_jump; // wait satisfied this cycle
    assign take_jump = wait_active_i & eval_en & (|row_hit);

    // jump request toward the sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            jump_valid_o <= 1'b0;
            jump_addr_o  <= '0;
            jump_row_o   <= 3'h0;
        end else begin
            jump_valid_o <= take_jump;
            if (take_jump) begin
                jump_addr_o <= sel_dest;
                jump_row_o  <= sel_row;
            end
        end
    end

    // ---------------- routing registers ----------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            current_route_select_o <= CUR_RST;
        end else if (is_cur) begin
            current_route_select_o <= instr_word_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            output_route_a_o <= RTA_RST;
            output_route_b_o <= RTB_RST;
            output_route_c_o <= RTC_RST;
        end else if (is_out) begin
            output_route_a_o <= instr_word_i[13:10];
            output_route_b_o <= instr_word_i[9:6];
            output_route_c_o <= instr_word_i[5:2];
        end
    end

    // gate pins claimed by any routing; codes 1100 up claim none
    wire [4:0] next_hs; // high-side pins claimed
    wire [6:0] next_ls; // low-side pins claimed
    for (genvar k = 0; k < 7; k++) begin : g_pin
        localparam logic [3:0] LS = 4'(k + `MCW_RT_LS_BASE);
        assign next_ls[k] = output_route_a_o == LS ||
                            output_route_b_o == LS ||
                            output_route_c_o == LS;
        if (k < 5) begin : g_hs
            localparam logic [3:0] HS = 4'(k);
            assign next_hs[k] = output_route_a_o == HS ||
                                output_route_b_o == HS ||
                                output_route_c_o == HS;
        end
    end

    // pin masks follow the routing one cycle later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_side_gate_pin_o <= 5'h00;
            low_side_gate_pin_o  <= 7'h00;
        end else begin
            high_side_gate_pin_o <= next_hs;
            low_side_gate_pin_o  <= next_ls;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    rel_dest_a: assert property (is_rel && row_ok |=>
        row_dest[$past(row_sel)] ==
        ADDR_W'($past(instr_addr_i) +
        ADDR_W'({{(ADDR_W-5){$past(instr_word_i[13])}},
                 $past(instr_word_i[13:9])})))
        else $error("row destination not address plus offset");
    row_enable_a: assert property (is_rel && row_ok |=>
        row_en[$past(row_sel)] && row_cond[$past(row_sel)] ==
        $past(instr_word_i[5:0]))
        else $error("written row not enabled with its trigger");
    bad_row_a: assert property (is_rel && !row_ok && !tbl_clear |=>
        $stable(row_en))
        else $error("out of range row changed the table");
    jump_hit_a: assert property (take_jump |=> jump_valid_o &&
        jump_addr_o == $past(sel_dest))
        else $error("hit row did not jump to its destination");
    no_hit_a: assert property (!(|row_hit) |=> !jump_valid_o)
        else $error("jump without any hit row");
    flag_code_a: assert property (cond_bus.truth[`MCW_T_FLAG_HI] ==
        flag_i[0] && cond_bus.truth[`MCW_T_COUNT] ==
        term_count_i[0])
        else $error("flag or count trigger misplaced");
    vds_code_a: assert property (cond_bus.truth[`MCW_T_VDS_HI] ==
        route_vds_fb_i[0] && cond_bus.truth[`MCW_T_SRC_LO] ==
        !route_src_fb_i[0])
        else $error("routed feedback trigger misplaced");
    boost_code_a: assert property (cond_bus.truth[`MCW_T_BOOST_HI] ==
        boost_high_i && cond_bus.truth[`MCW_T_ALU_DONE] ==
        alu_done_i)
        else $error("boost or alu trigger misplaced");
    cur_code_a: assert property (cond_bus.truth[`MCW_T_CUR_LO] ==
        !current_fb_i[0] && cond_bus.truth[`MCW_T_OWN_HI] ==
        current_fb_i[current_route_select_o])
        else $error("current trigger misplaced");
    cur_route_a: assert property (is_cur |=>
        current_route_select_o == $past(instr_word_i[1:0]))
        else $error("current routing not taken");
    out_route_a: assert property (is_out |=>
        output_route_b_o == $past(instr_word_i[9:6]) ##1
        ($past(output_route_a_o) > 4'h4 ||
         high_side_gate_pin_o[$past(output_route_a_o[2:0])]))
        else $error("output routing not taken");
    reset_route_a: assert property ($fell(rst_i) |->
        output_route_c_o == RTC_RST && current_route_select_o == CUR_RST)
        else $error("routing reset default wrong");
    bus_wait_a: assert property ((avs_read_i | avs_write_i) &&
        avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not one wait state");
endmodule
`default_nettype wire

/* design/mcw_row_eval.sv */
// one wait table row: selects its trigger from the truth vector
`timescale 1ns/1ps
`default_nettype none
module mcw_row_eval (
    mcw_cond_if.sink                cond,
    input  wire logic               enable_i,
    input  wire mcw_pkg::mcw_cond_t code_i,
    output logic                    hit_o
);
    // enabled row with its chosen trigger true
    assign hit_o = enable_i & cond.truth[code_i];
endmodule
`default_nettype wire

/* sim/tb_mcw_decoder.sv */
// self-checking bench for the wait table and routing decoder
`timescale 1ns/1ps
`default_nettype none
module tb_mcw_decoder;
    logic        clk_i           = 1'b0;    // 25 MHz clock
    logic        rst_i           = 1'b1;    // sync reset, active high
    logic [5:0]  avs_address_i   = 6'h00;   // register bus request
    logic        avs_read_i      = 1'b0;
    logic        avs_write_i     = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        instr_valid_i   = 1'b0;    // instruction issue
    logic [15:0] instr_word_i    = 16'h0;
    logic [9:0]  instr_addr_i    = 10'h0;
    logic        wait_active_i   = 1'b0;    // sequencer waiting
    logic        lvl             = 1'b0;    // level of every trigger source
    logic [1:0]  cur_sel;                   // routing outputs
    logic [3:0]  rt_a;
    logic [3:0]  rt_b;
    logic [3:0]  rt_c;
    logic [4:0]  hs_mask;
    logic [6:0]  ls_mask;
    logic        jump_valid;                // jump request
    logic [9:0]  jump_addr;
    logic [2:0]  jump_row;
    logic [31:0] rd;                        // last read data
    int          fails           = 0;
    int          total_checks    = 0;

    // clock, half period 20 ns
    always #20 clk_i = ~clk_i;

    mcw_decoder #(.ADDR_W(10), .CORE_SLOT(0)) i_mcw_decoder (
        .clk_i(clk_i), .rst_i(rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i),
        .instr_addr_i(instr_addr_i), .wait_active_i(wait_active_i),
        .flag_i({16{lvl}}), .term_count_i({4{lvl}}), .start_pin_i(lvl),
        .route_vds_fb_i({3{lvl}}), .route_src_fb_i({3{lvl}}),
        .alu_done_i(lvl), .boost_high_i(lvl), .current_fb_i({6{lvl}}),
        .current_route_select_o(cur_sel), .output_route_a_o(rt_a),
        .output_route_b_o(rt_b), .output_route_c_o(rt_c),
        .high_side_gate_pin_o(hs_mask), .low_side_gate_pin_o(ls_mask),
        .jump_valid_o(jump_valid), .jump_addr_o(jump_addr),
        .jump_row_o(jump_row)
    );

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] adr,
                       input logic [31:0] wd);
        @(posedge clk_i);
        avs_read_i      <= ~wr;
        avs_write_i     <= wr;
        avs_address_i   <= adr;
        avs_writedata_i <= wd;
        // only the watchdog ends a wait that never answers
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    // one instruction, valid for a single cycle
    task automatic issue(input logic [15:0] w, input logic [9:0] a);
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_word_i  <= w;
        instr_addr_i  <= a;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
    endtask

    // one waiting cycle, then look at the jump request
    task automatic wait_once();
        @(posedge clk_i);
        wait_active_i <= 1'b1;
        @(posedge clk_i);
        wait_active_i <= 1'b0;
        #1;
    endtask

    // relative row write word
    function automatic logic [15:0] rel(input logic [4:0] off,
                                        input logic [2:0] row,
                                        input logic [5:0] cnd);
        return {2'b11, off, row, cnd};
    endfunction

    // expected trigger truth when every source sits at level v
    function automatic logic exp_hit(input logic [5:0] c, input logic v);
        logic lo;
        lo = (c < 6'h10) || c == 6'h24 || (c >= 6'h26 && c <= 6'h2b) ||
             c == 6'h31 || (c >= 6'h38 && c <= 6'h3d) || c == 6'h3f;
        return lo ? ~v : v;
    endfunction

    // verdict and end of run
    task automatic complete_run();
        if (fails == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard, well beyond the expected run
    initial begin
        repeat (5000) @(posedge clk_i);
        fails++;
        complete_run();
    end

    // reset defaults of routing, masks and registers
    task automatic test_reset();
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        check(cur_sel, 2'h0);
        check({rt_a, rt_b, rt_c}, 12'h059);
        check({ls_mask, hs_mask}, {7'h11, 5'h01});
        bus(1'b0, 6'h00, 32'h0);
        check(rd, 32'h1);
        bus(1'b0, 6'h04, 32'h0);
        check(rd, 32'h9500);
        bus(1'b0, 6'h3c, 32'h0);
        check(rd, 32'h0);
    endtask

    // row writes, offsets, priority, enable and clear
    task automatic test_table();
        // negative offset into the last row, then a row past the table
        issue(rel(5'h10, 3'h4, 6'h10), 10'h100);
        issue(rel(5'h01, 3'h5, 6'h00), 10'h000);
        bus(1'b0, 6'h1c, 32'h0);
        check(rd, 32'h00f0_0010);
        bus(1'b0, 6'h08, 32'h0);
        check(rd, 32'h10);
        @(posedge clk_i);
        lvl <= 1'b1;
        wait_once();
        check({jump_valid, jump_row, jump_addr}, {1'b1, 3'h4, 10'h0f0});
        // two rows hit together, the lower one wins
        issue(rel(5'h0f, 3'h0, 6'h10), 10'h020);
        wait_once();
        check({jump_valid, jump_row, jump_addr}, {1'b1, 3'h0, 10'h02f});
        bus(1'b0, 6'h1c, 32'h0);
        check(rd, 32'h00f0_0010);
        bus(1'b0, 6'h08, 32'h0);
        check(rd, 32'h11);
        // evaluation off, then clear every row
        bus(1'b1, 6'h00, 32'h0);
        wait_once();
        check(jump_valid, 1'b0);
        bus(1'b1, 6'h00, 32'h3);
        wait_once();
        check(jump_valid, 1'b0);
    endtask

    // every trigger code with all sources low, then high
    task automatic test_triggers();
        for (int v = 0; v < 2; v++) begin
            @(posedge clk_i);
            lvl <= v[0];
            for (int c = 0; c < 64; c++) begin
                issue(rel(5'h00, 3'h0, c[5:0]), 10'h000);
                wait_once();
                check(jump_valid, exp_hit(c[5:0], v[0]));
            end
        end
    endtask

    // current routing, then output routing with an undefined code
    task automatic test_routing();
        issue(16'h357b, 10'h000);
        @(posedge clk_i);
        #1;
        check(cur_sel, 2'h3);
        issue(16'h92f3, 10'h000);
        repeat (2) @(posedge clk_i);
        #1;
        check({rt_a, rt_b, rt_c}, 12'h4bc);
        check({ls_mask, hs_mask}, {7'h40, 5'h10});
        issue(16'h92f0, 10'h000);
        repeat (2) @(posedge clk_i);
        #1;
        check({rt_a, rt_b, rt_c}, 12'h4bc);
        bus(1'b0, 6'h04, 32'h0);
        check(rd, 32'hcb43);
    endtask

    // main sequence
    initial begin
        test_reset();
        test_table();
        test_triggers();
        test_routing();
        complete_run();
    end
endmodule
`default_nettype wire
